// [common/fsp_pkg.sv]
// Constants shared by the frame statistics and pixel grabber block.
// Assumes a 20 MHz system clock and 7-bit pixels from the sensor core.
package fsp_pkg;
    localparam logic [6:0]  ADDR_SHUTTER_TIME_HIGH   = 7'h06;
    localparam logic [6:0]  ADDR_SHUTTER_TIME_LOW   = 7'h07;
    localparam logic [6:0]  ADDR_PIX_MAX   = 7'h08;
    localparam logic [6:0]  ADDR_PIX_SUM   = 7'h09;
    localparam logic [6:0]  ADDR_PIX_MIN   = 7'h0A;
    localparam logic [6:0]  ADDR_GRAB      = 7'h0B;
    localparam logic [15:0] SHUTTER_RESET  = 16'h0100;
    localparam logic [7:0]  STAT_RESET     = 8'h00;
    localparam logic [7:0]  MIN_RESET      = 8'h7F;
    localparam int          PIX_W          = 7;
    localparam int          NUM_PIXELS     = 361;
    localparam int          IDX_W          = 9;
    localparam int          FIFO_DEPTH     = 2;
    localparam int          BYTE_BITS      = 8;
    localparam int          DIR_BIT        = 7;
    localparam int          VALID_BIT      = 7;
    // Auto-exposure windows on the frame maximum and the summed-brightness byte
    localparam logic [7:0]  MAX_TOO_HIGH   = 8'h78;
    localparam logic [7:0]  MAX_TOO_LOW    = 8'h40;
    localparam logic [7:0]  SUM_TOO_HIGH   = 8'h80;
    localparam logic [7:0]  SUM_TOO_LOW    = 8'h30;
    localparam logic [15:0] SHUTTER_STEP   = 16'h0010;
    localparam logic [15:0] SHUTTER_FLOOR  = 16'h0010;
    localparam logic [15:0] SHUTTER_CEIL   = 16'hFF00;
endpackage

// [common/fsp_stream_if.sv]
// Valid/ready pixel stream between the input buffer and the frame logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface fsp_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [rtl/fsp_frame_stats.sv]
// Frame statistics, auto shutter and pixel grabber behind the four-wire serial port.
// Assumes serial mode with SCLK idle high, MOSI sampled on rising edges, MISO
// changed on falling edges; pixels arrive in raster order with a frame-start mark.
// How it works
// - The shutter time is a 16-bit cycle count read as a high byte at 0x06 and a low byte at 0x07.
// - The shutter is adjusted at the end of a frame whose peak or summed value is too high, or whose peak and sum are both too low.
// - The minimum pixel register holds the lowest 0..127 value of each frame, updated every frame.
// - Any write to the grabber register sends the grabber back to pixel 0.
`timescale 1ns/1ps
module fsp_frame_stats #(
    parameter int NPIX = fsp_pkg::NUM_PIXELS
) (
    input  wire logic                     MCLK,
    input  wire logic                     RST_N,
    input  wire logic                     NCS_N,
    input  wire logic                     SCLK,
    input  wire logic                     MOSI,
    output      logic                     MISO,
    output      logic                     MISO_OE,
    input  wire logic                     PIX_VALID,
    output      logic                     PIX_READY,
    input  wire logic                     PIX_SOF,
    input  wire logic [fsp_pkg::PIX_W-1:0] PIX_DATA,
    output      logic [15:0]              SHUTTER
);
    import fsp_pkg::*;
    localparam int SW = PIX_W + 1;
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NPIX - 1);
    localparam logic [IDX_W-1:0] END_IDX  = IDX_W'(NPIX);

    typedef enum logic [1:0] {SER_ADDR, SER_WDATA, SER_RDATA} fsp_ser_t;

    // Serial pins come from the controller's domain
    logic [2:0]  sclk_sync_reg;
    logic [1:0]  ncs_sync_reg;
    logic [1:0]  mosi_sync_reg;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sel;
    fsp_ser_t    ser_state_reg;
    logic [2:0]  bit_cnt_reg;
    logic [7:0]  rx_shift_reg;
    logic [7:0]  tx_shift_reg;
    logic [6:0]  addr_reg;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic        rd_load;
    logic        wr_event;
    logic [7:0]  rd_data;
    logic        grab_valid;

    logic [15:0]      shutter_reg;
    logic [7:0]       shutter_time_low_hold_reg;
    logic             shut_hold_reg;
    logic [7:0]       max_reg;
    logic [7:0]       sum_hi_reg;
    logic [7:0]       min_reg;
    logic [PIX_W-1:0] run_min_reg;
    logic [PIX_W-1:0] run_max_reg;
    logic [15:0]      run_sum_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [PIX_W-1:0] image_reg [NPIX];
    logic [IDX_W-1:0] grab_pos_reg;
    logic             image_ready_reg;

    fsp_stream_if #(.W(SW)) pix_if ();

    fsp_pixel_buffer #(.W(SW), .DEPTH(FIFO_DEPTH)) u_buf (
        .clk      (MCLK),
        .rst_n    (RST_N),
        .in_valid (PIX_VALID),
        .in_ready (PIX_READY),
        .in_data  ({PIX_SOF, PIX_DATA}),
        .out      (pix_if.src)
    );

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sclk_sync_reg <= 3'b111;
            ncs_sync_reg  <= 2'b11;
            mosi_sync_reg <= 2'b00;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
            ncs_sync_reg  <= {ncs_sync_reg[0], NCS_N};
            mosi_sync_reg <= {mosi_sync_reg[0], MOSI};
        end
    end

    assign sel       = !ncs_sync_reg[1];
    assign sclk_rise = sel && sclk_sync_reg[1] && !sclk_sync_reg[2];
    assign sclk_fall = sel && !sclk_sync_reg[1] && sclk_sync_reg[2];
    assign rx_byte   = {rx_shift_reg[6:0], mosi_sync_reg[1]};
    assign byte_done = sclk_rise && (bit_cnt_reg == 3'(BYTE_BITS - 1));
    assign rd_load   = byte_done && (ser_state_reg == SER_ADDR) && !rx_byte[DIR_BIT];
    assign wr_event  = byte_done && (ser_state_reg == SER_WDATA);
    assign grab_valid = image_ready_reg && (grab_pos_reg < END_IDX);

    always_comb begin
        rd_data = STAT_RESET;
        if (rx_byte[6:0] == ADDR_SHUTTER_TIME_HIGH) begin
            rd_data = shutter_reg[15:8];
        end else if (rx_byte[6:0] == ADDR_SHUTTER_TIME_LOW) begin
            // Pairs with the high byte taken earlier so a frame update cannot split them
            rd_data = shut_hold_reg ? shutter_time_low_hold_reg : shutter_reg[7:0];
        end else if (rx_byte[6:0] == ADDR_PIX_MAX) begin
            rd_data = max_reg;
        end else if (rx_byte[6:0] == ADDR_PIX_SUM) begin
            rd_data = sum_hi_reg;
        end else if (rx_byte[6:0] == ADDR_PIX_MIN) begin
            rd_data = min_reg;
        end else if (rx_byte[6:0] == ADDR_GRAB) begin
            // Reads as zero before the first frame and past the last pixel, never stale storage
            if (grab_valid) begin
                rd_data = {1'b1, image_reg[grab_pos_reg]};
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N || !sel) begin
            ser_state_reg <= SER_ADDR;
            bit_cnt_reg   <= '0;
            rx_shift_reg  <= '0;
            addr_reg      <= '0;
        end else if (sclk_rise) begin
            rx_shift_reg <= rx_byte;
            bit_cnt_reg  <= bit_cnt_reg + 3'(1);
            if (byte_done) begin
                case (ser_state_reg)
                    SER_ADDR: begin
                        addr_reg      <= rx_byte[6:0];
                        ser_state_reg <= rx_byte[DIR_BIT] ? SER_WDATA : SER_RDATA;
                    end
                    default: begin
                        ser_state_reg <= SER_ADDR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            tx_shift_reg <= '0;
            MISO         <= 1'b0;
            MISO_OE      <= 1'b0;
        end else begin
            MISO_OE <= sel && (ser_state_reg == SER_RDATA);
            if (rd_load) begin
                tx_shift_reg <= rd_data;
            end else if (sclk_fall && ser_state_reg == SER_RDATA) begin
                MISO         <= tx_shift_reg[7];
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    // Low byte is frozen when the high byte is read
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            shutter_time_low_hold_reg <= SHUTTER_RESET[7:0];
            shut_hold_reg    <= 1'b0;
        end else if (rd_load && rx_byte[6:0] == ADDR_SHUTTER_TIME_HIGH) begin
            shutter_time_low_hold_reg <= shutter_reg[7:0];
            shut_hold_reg    <= 1'b1;
        end else if (rd_load) begin
            shut_hold_reg    <= 1'b0;
        end
    end

    // Frame engine: the buffer is drained except in a cycle that loads a grab byte
    logic             pix_take;
    logic             pix_sof;
    logic [PIX_W-1:0] pix_val;
    logic [IDX_W-1:0] idx_cur;
    logic [PIX_W-1:0] min_cur;
    logic [PIX_W-1:0] max_cur;
    logic [15:0]      sum_cur;
    logic             frame_end;

    assign pix_if.ready = !(rd_load && rx_byte[6:0] == ADDR_GRAB);
    assign pix_take     = pix_if.valid && pix_if.ready;
    assign pix_sof      = pix_if.data[PIX_W];
    assign pix_val      = pix_if.data[PIX_W-1:0];
    assign idx_cur      = pix_sof ? '0 : idx_reg + IDX_W'(1);
    assign min_cur      = (pix_sof || pix_val < run_min_reg) ? pix_val : run_min_reg;
    assign max_cur      = (pix_sof || pix_val > run_max_reg) ? pix_val : run_max_reg;
    assign sum_cur      = (pix_sof ? 16'h0000 : run_sum_reg) + 16'(pix_val);
    assign frame_end    = pix_take && (idx_cur == LAST_IDX);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            idx_reg     <= END_IDX;
            run_min_reg <= '0;
            run_max_reg <= '0;
            run_sum_reg <= '0;
        end else if (pix_take && idx_cur < END_IDX) begin
            idx_reg     <= idx_cur;
            run_min_reg <= min_cur;
            run_max_reg <= max_cur;
            run_sum_reg <= sum_cur;
        end
    end

    // A new frame overwrites the image while a grab is in progress; hold the sensor still
    always_ff @(posedge MCLK) begin
        if (pix_take && idx_cur < END_IDX) begin
            image_reg[idx_cur] <= pix_val;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            max_reg    <= STAT_RESET;
            sum_hi_reg <= STAT_RESET;
            min_reg    <= MIN_RESET;
        end else if (frame_end) begin
            max_reg    <= 8'(max_cur);
            sum_hi_reg <= sum_cur[15:8];
            min_reg    <= 8'(min_cur);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            shutter_reg <= SHUTTER_RESET;
            SHUTTER     <= SHUTTER_RESET;
        end else begin
            SHUTTER <= shutter_reg;
            if (frame_end) begin
                if ((8'(max_cur) >= MAX_TOO_HIGH || sum_cur[15:8] > SUM_TOO_HIGH)
                    && shutter_reg >= SHUTTER_FLOOR + SHUTTER_STEP) begin
                    shutter_reg <= shutter_reg - SHUTTER_STEP;
                end else if (8'(max_cur) < MAX_TOO_LOW && sum_cur[15:8] < SUM_TOO_LOW
                    && shutter_reg <= SHUTTER_CEIL - SHUTTER_STEP) begin
                    shutter_reg <= shutter_reg + SHUTTER_STEP;
                end
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            grab_pos_reg    <= '0;
            image_ready_reg <= 1'b0;
        end else begin
            if (frame_end) begin
                image_ready_reg <= 1'b1;
            end
            if (wr_event && addr_reg == ADDR_GRAB) begin
                grab_pos_reg <= '0;
            end else if (rd_load && rx_byte[6:0] == ADDR_GRAB && grab_pos_reg < END_IDX) begin
                grab_pos_reg <= grab_pos_reg + IDX_W'(1);
            end
        end
    end
endmodule

// [rtl/fsp_pixel_buffer.sv]
// Two-entry pixel buffer with valid and ready on both sides.
// Assumes the writer holds data while its ready is low.
`timescale 1ns/1ps
module fsp_pixel_buffer #(
    parameter int W     = 8,
    parameter int DEPTH = fsp_pkg::FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output      logic         in_ready,
    input  wire logic [W-1:0] in_data,
    fsp_stream_if.src         out
);
    import fsp_pkg::*;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          push;
    logic          pop;

    assign push = in_valid && in_ready;
    assign pop  = out.valid && out.ready;
    assign out.valid = (count_reg != '0);
    assign out.data  = mem_reg[rd_ptr_reg];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + CW'(1);
        end else if (pop && !push) begin
            count_next = count_reg - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            in_ready  <= 1'b0;
        end else begin
            count_reg <= count_next;
            // Registered ready; stalls the source as soon as both slots hold words
            in_ready  <= (count_next != FULL);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule

// [verif/fsp_ctrl_model.sv]
// Serial controller model: drives the four-wire port in mode 3, collects read bytes.
// Assumes the block samples SCLK with MCLK; SCLK stands high between frames.
`timescale 1ns/1ps
module fsp_ctrl_model
    import fsp_pkg::*;
(
    input  wire logic       clk,
    output      logic       ncs_n,
    output      logic       sclk,
    output      logic       mosi,
    input  wire logic       miso,
    input  wire logic       miso_oe,
    output      logic       rd_done,
    output      logic [7:0] rd_data
);
    logic miso_last = 1'b0;
    logic miso_seen;
    // A released line shows the inverse of its last bit, so stale data never matches
    assign miso_seen = miso_oe ? miso : ~miso_last;
    always @(posedge clk) begin
        if (miso_oe === 1'b1) miso_last <= miso;
    end
    initial begin
        ncs_n = 1'b1;
        sclk = 1'b1;
        mosi = 1'b0;
        rd_done = 1'b0;
        rd_data = 8'h00;
    end
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata);
        logic [15:0] sh;
        logic [7:0]  rx;
        sh = {wr, addr, wdata};
        rx = 8'h00;
        ncs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= sh[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            if (i < 8) rx = {rx[6:0], miso_seen};
            repeat (4) @(posedge clk);
        end
        ncs_n <= 1'b1;
        if (!wr) begin
            rd_data <= rx;
            rd_done <= 1'b1;
        end
        @(posedge clk);
        rd_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic shutter_read();
        xfer(1'b0, ADDR_SHUTTER_TIME_HIGH, 8'h00);
        xfer(1'b0, ADDR_SHUTTER_TIME_LOW, 8'h00);
    endtask
endmodule

// [verif/fsp_frame_stats_properties.sv]
// Concurrent checks on the shutter output, pixel stream and serial outputs.
// Assumes a single MCLK domain; bound to every instance of the top module.
`timescale 1ns/1ps
module fsp_frame_stats_chk
    import fsp_pkg::*;
#(
    parameter int NPIX = NUM_PIXELS
) (
    input wire logic             MCLK,
    input wire logic             RST_N,
    input wire logic             NCS_N,
    input wire logic             SCLK,
    input wire logic             MOSI,
    input wire logic             MISO,
    input wire logic             MISO_OE,
    input wire logic             PIX_VALID,
    input wire logic             PIX_READY,
    input wire logic             PIX_SOF,
    input wire logic [PIX_W-1:0] PIX_DATA,
    input wire logic [15:0]      SHUTTER
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    sequence s_released; $rose(RST_N); endsequence
    sequence s_stream_idle; !PIX_VALID [*8]; endsequence
    sequence s_cs_idle; NCS_N [*4]; endsequence
    property p_shutter_init; s_released |-> SHUTTER == SHUTTER_RESET; endproperty
    property p_ready_up; s_released |-> !PIX_READY ##1 PIX_READY; endproperty
    property p_shutter_range; SHUTTER >= SHUTTER_FLOOR && SHUTTER <= SHUTTER_CEIL; endproperty
    property p_shutter_step;
        $changed(SHUTTER) |-> (SHUTTER - $past(SHUTTER)) == SHUTTER_STEP
            || ($past(SHUTTER) - SHUTTER) == SHUTTER_STEP;
    endproperty
    // Shutter moves only as a result of a finished frame
    property p_shutter_idle; s_stream_idle |=> $stable(SHUTTER); endproperty
    property p_oe_cs; $rose(MISO_OE) |-> !NCS_N; endproperty
    property p_oe_drop; s_cs_idle |-> !MISO_OE; endproperty
    property p_miso_fall; MISO_OE && $past(MISO_OE) && $changed(MISO) |-> !SCLK; endproperty
    a_shutter_init: assert property (p_shutter_init) else $error("shutter not at reset value");
    a_ready_up: assert property (p_ready_up) else $error("pixel ready late after reset");
    a_shutter_range: assert property (p_shutter_range) else $error("shutter out of range");
    a_shutter_step: assert property (p_shutter_step) else $error("shutter step wrong");
    a_shutter_idle: assert property (p_shutter_idle) else $error("shutter moved idle");
    a_oe_cs: assert property (p_oe_cs) else $error("output enable without select");
    a_oe_drop: assert property (p_oe_drop) else $error("output enable stuck");
    a_miso_fall: assert property (p_miso_fall) else $error("data out changed at high clock");
endmodule

bind fsp_frame_stats fsp_frame_stats_chk #(.NPIX(NPIX)) chk_u (.MCLK(MCLK), .RST_N(RST_N),
    .NCS_N(NCS_N), .SCLK(SCLK), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE),
    .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_SOF(PIX_SOF), .PIX_DATA(PIX_DATA),
    .SHUTTER(SHUTTER));

// [verif/test_fsp_frame_stats.sv]
// Self-checking bench: pixel frames in, register reads out through the serial model.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_fsp_frame_stats;
    import fsp_pkg::*;
    logic        mclk, rst_n, pix_valid, pix_sof, ncs_n, sclk, mosi, miso, miso_oe;
    logic        pix_ready, rd_done;
    logic [6:0]  pix_data;
    logic [7:0]  rd_data, mx, mn;
    logic [15:0] shutter, exp_sh, sum;
    logic [6:0]  img [NUM_PIXELS];
    logic [15:0] exp_q [$];
    int          n_fail, checks, cyc;

    fsp_frame_stats dut_u (.MCLK(mclk), .RST_N(rst_n), .NCS_N(ncs_n), .SCLK(sclk),
        .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .PIX_VALID(pix_valid),
        .PIX_READY(pix_ready), .PIX_SOF(pix_sof), .PIX_DATA(pix_data), .SHUTTER(shutter));
    fsp_ctrl_model model_u (.clk(mclk), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .rd_done(rd_done), .rd_data(rd_data));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g,
                        input logic [7:0] m);
        checks++;
        if ((g & m) !== (e & m)) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (rd_done === 1'b1 && exp_q.size() > 0) begin
            cmp8("register read", exp_q[0][7:0], rd_data, exp_q[0][15:8]);
            void'(exp_q.pop_front());
        end
        if (cyc == 80000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e});
        model_u.xfer(1'b0, a, 8'($urandom));
    endtask
    function automatic logic [15:0] shut_next(input logic [15:0] s);
        if (mx >= MAX_TOO_HIGH || sum[15:8] > SUM_TOO_HIGH)
            return (s < SHUTTER_FLOOR + SHUTTER_STEP) ? SHUTTER_FLOOR : s - SHUTTER_STEP;
        if (mx < MAX_TOO_LOW && sum[15:8] < SUM_TOO_LOW)
            return (s > SHUTTER_CEIL - SHUTTER_STEP) ? SHUTTER_CEIL : s + SHUTTER_STEP;
        return s;
    endfunction
    // Kind 1 is bright, kind 2 dark, kind 0 fully random; gaps stall the stream at random
    task automatic send_frame(input int kind);
        logic [6:0] p;
        mx = 8'h00;
        mn = 8'h7F;
        sum = 16'h0000;
        for (int i = 0; i < NUM_PIXELS; i++) begin
            p = (kind == 1) ? (7'h70 | 7'($urandom)) : (kind == 2) ? (7'($urandom) & 7'h1F)
                : 7'($urandom);
            img[i] = p;
            sum += 16'(p);
            if ({1'b0, p} > mx) mx = {1'b0, p};
            if ({1'b0, p} < mn) mn = {1'b0, p};
            if ($urandom % 4 == 0) begin
                pix_valid <= 1'b0;
                @(posedge mclk);
            end
            pix_valid <= 1'b1;
            pix_sof <= (i == 0);
            pix_data <= p;
            @(posedge mclk);
            while (pix_ready !== 1'b1) @(posedge mclk);
        end
        pix_valid <= 1'b0;
        pix_sof <= 1'b0;
        repeat (12) @(posedge mclk);
        exp_sh = shut_next(exp_sh);
        cmp16("shutter port", exp_sh, shutter);
        rd(ADDR_PIX_MAX, mx, 8'hFF);
        rd(ADDR_PIX_SUM, sum[15:8], 8'hFF);
        rd(ADDR_PIX_MIN, mn, 8'hFF);
        exp_q.push_back({8'hFF, exp_sh[15:8]});
        exp_q.push_back({8'hFF, exp_sh[7:0]});
        model_u.shutter_read();
    endtask
    initial begin
        rst_n = 1'b0;
        pix_valid = 1'b0;
        pix_sof = 1'b0;
        pix_data = 7'h00;
        n_fail = 0;
        checks = 0;
        cyc = 0;
        exp_sh = SHUTTER_RESET;
        void'($urandom(12723));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(ADDR_SHUTTER_TIME_HIGH, 8'h01, 8'hFF);
        rd(ADDR_SHUTTER_TIME_LOW, 8'h00, 8'hFF);
        rd(ADDR_PIX_MAX, 8'h00, 8'hFF);
        rd(ADDR_PIX_SUM, 8'h00, 8'hFF);
        rd(ADDR_PIX_MIN, MIN_RESET, 8'hFF);
        rd(ADDR_GRAB, 8'h00, 8'hFF);
        rd(7'h1F, 8'h00, 8'hFF);
        for (int k = 1; k < 4; k++) send_frame(k % 3);
        model_u.xfer(1'b1, ADDR_PIX_MAX, ~mx);
        rd(ADDR_PIX_MAX, mx, 8'hFF);
        model_u.xfer(1'b1, ADDR_GRAB, 8'($urandom));
        for (int i = 0; i < NUM_PIXELS; i++) rd(ADDR_GRAB, {1'b1, img[i]}, 8'hFF);
        rd(ADDR_GRAB, 8'h00, 8'hFF);
        model_u.xfer(1'b1, ADDR_GRAB, 8'($urandom));
        rd(ADDR_GRAB, {1'b1, img[0]}, 8'hFF);
        repeat (4) @(posedge mclk);
        if (exp_q.size() != 0) n_fail++;
        conclude();
    end
endmodule
